// *** fepg_gate.sv ***
`timescale 1ns/1ns
`include "fepg_defines.svh"

// Operation
// - The array holds 96 KB split into 1 KB blocks, each erasable without touching others.
// - Erasing a block writes all ones into every word of that 1 KB block.
// - Protection is kept per 2 KB unit covering two adjacent blocks, each unit independent.
// - Each unit carries an attribute of read-only, execute-only or open.
// - Erase and program aimed at a read-only unit are refused and the contents stay.
// - Erase and program aimed at an execute-only unit are refused and the contents stay.
// - An execute-only unit returns data only to instruction fetches, not data or debug reads.
// - A read is answered one clock after it is taken, with no wait states.
module fepg_gate #(
    parameter int ADDR_W = `FEPG_ADDR_W,
    parameter int WORDS = `FEPG_WORDS,
    parameter int UNITS = `FEPG_NUM_UNITS
) (
    input wire logic CLOCK_IN, // System clock
    input wire logic SRST_IN, // Sync reset, active high
    input wire logic RD_REQ_IN, // Read request
    input wire logic [1:0] RD_SRC_IN, // Read requester kind
    input wire logic [ADDR_W-1:0] RD_ADDR_IN, // Read word address
    input wire logic PROG_REQ_IN, // Program request
    input wire logic [ADDR_W-1:0] PROG_ADDR_IN, // Program word address
    input wire logic [31:0] PROG_DATA_IN, // Program data
    input wire logic ERASE_REQ_IN, // Block erase request
    input wire logic [6:0] ERASE_BLOCK_IN, // Erase block index
    input wire logic ATTR_WE_IN, // Attribute write strobe
    input wire logic [5:0] ATTR_UNIT_IN, // Attribute unit index
    input wire logic [1:0] ATTR_VAL_IN, // Attribute value
    input wire logic VIOL_CLR_IN, // Clear violation flag
    output logic RD_VALID_OUT, // Read data valid
    output logic [31:0] RD_DATA_OUT, // Read data
    output logic RD_BLOCKED_OUT, // Read was withheld
    output logic BUSY_OUT, // Erase in progress
    output logic OP_REFUSED_OUT, // Refused write-type op pulse
    output logic VIOL_OUT // Sticky violation flag
);
    // ******************************
    // Storage
    // ******************************
    logic [31:0] mem_q [WORDS];
    // Attributes come back open after reset; keeping them is the owner's job
    logic [1:0] attr_q [UNITS];
    fepg_pkg::fepg_state_t state_q, state_d;
    logic [`FEPG_BLOCK_AW-1:0] ecnt_q, ecnt_d;
    logic [6:0] eblk_q, eblk_d;
    logic rd_valid_q, rd_valid_d;
    logic [31:0] rd_data_q, rd_data_d;
    logic rd_blk_q, rd_blk_d;
    logic refused_q, refused_d;
    logic viol_q, viol_d;
    logic busy_q, busy_d;
    logic prog_ok, erase_ok, rd_ok;

    // Single array write port, shared by erase walk and program
    logic mem_we;
    logic [ADDR_W-1:0] mem_wa;
    logic [31:0] mem_wd;

    // ******************************
    // Helpers
    // ******************************
    // Unit index of a word address
    function automatic logic [5:0] unit_of(input logic [ADDR_W-1:0] a);
        unit_of = a[ADDR_W-1:`FEPG_UNIT_SHIFT];
    endfunction

    // Read-only and execute-only both lock the contents
    function automatic logic wr_locked(input logic [1:0] attr);
        wr_locked = (attr == fepg_pkg::FEPG_ATTR_RO)
            || (attr == fepg_pkg::FEPG_ATTR_XO);
    endfunction

    // Units past the array count as open, so stray addresses never decode X
    function automatic logic [1:0] attr_of(input logic [5:0] u);
        if (u < 6'(UNITS)) begin
            attr_of = attr_q[u];
        end else begin
            attr_of = fepg_pkg::FEPG_ATTR_OPEN;
        end
    endfunction

    // ******************************
    // Control
    // ******************************
    always_comb begin
        state_d = state_q;
        ecnt_d = ecnt_q;
        eblk_d = eblk_q;
        refused_d = 1'b0;
        rd_ok = 1'b1;
        prog_ok = 1'b0;
        erase_ok = 1'b0;
        if (attr_of(unit_of(RD_ADDR_IN)) == fepg_pkg::FEPG_ATTR_XO
            && RD_SRC_IN != fepg_pkg::FEPG_REQ_IFETCH) begin
            rd_ok = 1'b0;
        end
        // Erase beats program when both arrive together
        case (state_q)
            fepg_pkg::FEPG_ST_IDLE: begin
                if (ERASE_REQ_IN && ERASE_BLOCK_IN < 7'(`FEPG_NUM_BLOCKS)) begin
                    if (wr_locked(attr_of(ERASE_BLOCK_IN[6:1]))) begin
                        refused_d = 1'b1;
                    end else begin
                        erase_ok = 1'b1;
                        eblk_d = ERASE_BLOCK_IN;
                        ecnt_d = '0;
                        state_d = fepg_pkg::FEPG_ST_ERASE;
                    end
                end else if (PROG_REQ_IN) begin
                    if (wr_locked(attr_of(unit_of(PROG_ADDR_IN)))) begin
                        refused_d = 1'b1;
                    end else begin
                        prog_ok = 1'b1;
                    end
                end
            end
            fepg_pkg::FEPG_ST_ERASE: begin
                // Program and erase requests during erase are dropped; BUSY tells the requester
                // Last word is written when the count is all ones
                ecnt_d = ecnt_q + 1'b1;
                if (ecnt_q == '1) begin
                    state_d = fepg_pkg::FEPG_ST_IDLE;
                end
            end
            default: begin
                state_d = fepg_pkg::FEPG_ST_IDLE;
            end
        endcase

        // Reads are served in any state, also mid-erase
        rd_valid_d = RD_REQ_IN;
        rd_blk_d = RD_REQ_IN && !rd_ok;
        // A blocked read answers zeros, never stale data
        rd_data_d = (RD_REQ_IN && rd_ok) ? mem_q[RD_ADDR_IN] : `FEPG_ZERO_WORD;
        // Set wins over a clear in the same cycle
        viol_d = refused_d || rd_blk_d || (viol_q && !VIOL_CLR_IN);
        // Registered so the busy output leaves a flop directly
        busy_d = erase_ok || (state_q == fepg_pkg::FEPG_ST_ERASE && ecnt_q != '1);
    end

    // Control and read-path registers
    always_ff @(posedge CLOCK_IN) begin
        if (SRST_IN) begin
            state_q <= fepg_pkg::FEPG_ST_IDLE;
            ecnt_q <= '0;
            eblk_q <= '0;
            rd_valid_q <= 1'b0;
            rd_data_q <= `FEPG_ZERO_WORD;
            rd_blk_q <= 1'b0;
            refused_q <= 1'b0;
            viol_q <= 1'b0;
            busy_q <= 1'h0;
        end else begin
            state_q <= state_d;
            ecnt_q <= ecnt_d;
            eblk_q <= eblk_d;
            rd_valid_q <= rd_valid_d;
            rd_data_q <= rd_data_d;
            rd_blk_q <= rd_blk_d;
            refused_q <= refused_d;
            viol_q <= viol_d;
            busy_q <= busy_d;
        end
    end

    // ******************************
    // Array and attributes
    // ******************************
    // Erase walks one word per clock; a reset cuts the walk short, as power loss would
    always_comb begin
        mem_we = 1'h0;
        mem_wa = PROG_ADDR_IN;
        // Flash program can only clear bits
        mem_wd = mem_q[PROG_ADDR_IN] & PROG_DATA_IN;
        if (!SRST_IN && state_q == fepg_pkg::FEPG_ST_ERASE) begin
            mem_we = 1'h1;
            mem_wa = ADDR_W'({eblk_q, ecnt_q});
            mem_wd = `FEPG_ERASED_WORD;
        end else if (!SRST_IN && prog_ok) begin
            mem_we = 1'h1;
        end
    end

    // Array content survives reset, as flash does
    always_ff @(posedge CLOCK_IN) begin
        if (mem_we) begin
            mem_q[mem_wa] <= mem_wd;
        end
    end

    // One attribute register per 2 KB unit
    genvar gu;
    generate
        for (gu = 0; gu < UNITS; gu++) begin : g_unit
            logic [1:0] attr_d;
            always_comb begin
                attr_d = attr_q[gu];
                if (ATTR_WE_IN && ATTR_UNIT_IN == 6'(gu)) begin
                    attr_d = ATTR_VAL_IN;
                end
            end
            always_ff @(posedge CLOCK_IN) begin
                if (SRST_IN) begin
                    attr_q[gu] <= `FEPG_ATTR_RESET;
                end else begin
                    attr_q[gu] <= attr_d;
                end
            end
        end
    endgenerate

    // ******************************
    // Outputs
    // ******************************
    // Every output is a bare flop, so the requester sees no decode delay
    assign RD_VALID_OUT = rd_valid_q;
    assign RD_DATA_OUT = rd_data_q;
    assign RD_BLOCKED_OUT = rd_blk_q;
    assign BUSY_OUT = busy_q;
    assign OP_REFUSED_OUT = refused_q;
    assign VIOL_OUT = viol_q;
endmodule // fepg_gate

// *** fepg_defines.svh ***
`ifndef FEPG_DEFINES_SVH
`define FEPG_DEFINES_SVH

// Array geometry, 32-bit words
`define FEPG_WORD_W 32
`define FEPG_ADDR_W 15
`define FEPG_WORDS 24576
`define FEPG_BLOCK_AW 8
`define FEPG_NUM_BLOCKS 96
`define FEPG_NUM_UNITS 48
`define FEPG_UNIT_SHIFT 9
`define FEPG_ERASED_WORD 32'hFFFFFFFF
`define FEPG_ZERO_WORD 32'h00000000
`define FEPG_ATTR_RESET 2'h0

`endif

// *** fepg_pkg.sv ***
package fepg_pkg;
    typedef enum logic [1:0] {
        FEPG_ATTR_OPEN = 2'b00,
        FEPG_ATTR_RO = 2'b01,
        FEPG_ATTR_XO = 2'b10
    } fepg_attr_t;

    typedef enum logic [1:0] {
        FEPG_REQ_IFETCH = 2'b00,
        FEPG_REQ_DATA = 2'b01,
        FEPG_REQ_DEBUG = 2'b10
    } fepg_src_t;

    typedef enum logic [0:0] {
        FEPG_ST_IDLE = 1'b0,
        FEPG_ST_ERASE = 1'b1
    } fepg_state_t;
endpackage

// *** fepg_gate_properties.sv ***
`timescale 1ns/1ns
// ****
// Port checks
// ****
module fepg_chk (
    input wire logic CLOCK_IN, // Clock
    input wire logic SRST_IN, // Reset
    input wire logic RD_REQ_IN, // Read
    input wire logic [1:0] RD_SRC_IN, // Kind
    input wire logic VIOL_CLR_IN, // Clear
    input wire logic RD_VALID_OUT, // Valid
    input wire logic [31:0] RD_DATA_OUT, // Data
    input wire logic RD_BLOCKED_OUT, // Withheld
    input wire logic BUSY_OUT, // Busy
    input wire logic OP_REFUSED_OUT, // Refused
    input wire logic VIOL_OUT // Sticky
);
    default clocking @(posedge CLOCK_IN); endclocking
    default disable iff (SRST_IN);
    logic [8:0] busy_q;
    logic [8:0] busy_d;
    always_comb busy_d = BUSY_OUT ? busy_q + 9'h1 : 9'h0;
    always_ff @(posedge CLOCK_IN) busy_q <= SRST_IN ? 9'h0 : busy_d;
    AST_RD_LAT: assert property (RD_REQ_IN |=> RD_VALID_OUT) else $error("late read");
    AST_RD_IDLE: assert property (!RD_REQ_IN |=> !RD_VALID_OUT && RD_DATA_OUT == 32'h0)
        else $error("stray read");
    AST_BLK_ZERO: assert property (RD_BLOCKED_OUT |-> RD_DATA_OUT == 32'h0 && VIOL_OUT)
        else $error("leak");
    AST_FETCH_OK: assert property (RD_REQ_IN && RD_SRC_IN == 2'h0 |=> !RD_BLOCKED_OUT)
        else $error("fetch withheld");
    AST_REF_FLAG: assert property (OP_REFUSED_OUT |-> VIOL_OUT && !$past(BUSY_OUT))
        else $error("bad refusal");
    AST_VIOL_HOLD: assert property (VIOL_OUT && !VIOL_CLR_IN |=> VIOL_OUT) else $error("lost");
    AST_VIOL_WHY: assert property ($rose(VIOL_OUT) |-> RD_BLOCKED_OUT || OP_REFUSED_OUT)
        else $error("no cause");
    AST_ERASE_LEN: assert property ($fell(BUSY_OUT) |-> busy_q == 9'h100)
        else $error("erase length");
endmodule // fepg_chk
bind fepg_gate fepg_chk u_chk (
    .CLOCK_IN(CLOCK_IN),
    .SRST_IN(SRST_IN),
    .RD_REQ_IN(RD_REQ_IN),
    .RD_SRC_IN(RD_SRC_IN),
    .VIOL_CLR_IN(VIOL_CLR_IN),
    .RD_VALID_OUT(RD_VALID_OUT),
    .RD_DATA_OUT(RD_DATA_OUT),
    .RD_BLOCKED_OUT(RD_BLOCKED_OUT),
    .BUSY_OUT(BUSY_OUT),
    .OP_REFUSED_OUT(OP_REFUSED_OUT),
    .VIOL_OUT(VIOL_OUT)
);

// *** fepg_req_model.sv ***
`timescale 1ns/1ns
// ****
// Fetch, data and debug requester
// ****
module fepg_req_model (
    input wire logic clk_in, // Clock
    output logic req_out = 1'b0, // Strobe
    output logic [1:0] src_out = 2'h0, // Kind
    output logic [14:0] addr_out = 15'h0 // Address
);
    task automatic rd(input logic [1:0] s, logic [14:0] a);
        @(posedge clk_in);
        #1 {req_out, src_out, addr_out} = {1'b1, s, a};
        @(posedge clk_in);
        #1 req_out = 1'b0;
        addr_out = ~a; // Released lines must not keep the old address
    endtask
endmodule // fepg_req_model

// *** tb_top.sv ***
`timescale 1ns/1ns
// ****
// Gate regression
// ****
module tb_top;
    logic CLOCK_IN = 1'b0, SRST_IN = 1'b1, PROG_REQ_IN = 1'b0, ERASE_REQ_IN = 1'b0;
    logic ATTR_WE_IN = 1'b0, VIOL_CLR_IN = 1'b0, RD_REQ_IN, RD_VALID_OUT, RD_BLOCKED_OUT;
    logic BUSY_OUT, OP_REFUSED_OUT, VIOL_OUT, refd;
    logic [1:0] RD_SRC_IN;
    logic [14:0] RD_ADDR_IN, PROG_ADDR_IN = 15'h0;
    logic [31:0] PROG_DATA_IN = 32'h0, RD_DATA_OUT;
    int n_mismatch = 0, tests_run = 0;
    always #25 CLOCK_IN = ~CLOCK_IN;
    fepg_gate DUT (.CLOCK_IN(CLOCK_IN), .SRST_IN(SRST_IN), .RD_REQ_IN(RD_REQ_IN),
        .RD_SRC_IN(RD_SRC_IN), .RD_ADDR_IN(RD_ADDR_IN), .PROG_REQ_IN(PROG_REQ_IN),
        .PROG_ADDR_IN(PROG_ADDR_IN), .PROG_DATA_IN(PROG_DATA_IN), .ERASE_REQ_IN(ERASE_REQ_IN),
        .ERASE_BLOCK_IN(PROG_ADDR_IN[6:0]), .ATTR_WE_IN(ATTR_WE_IN),
        .ATTR_UNIT_IN(PROG_ADDR_IN[5:0]), .ATTR_VAL_IN(PROG_DATA_IN[1:0]),
        .VIOL_CLR_IN(VIOL_CLR_IN), .RD_VALID_OUT(RD_VALID_OUT), .RD_DATA_OUT(RD_DATA_OUT),
        .RD_BLOCKED_OUT(RD_BLOCKED_OUT), .BUSY_OUT(BUSY_OUT),
        .OP_REFUSED_OUT(OP_REFUSED_OUT), .VIOL_OUT(VIOL_OUT));
    fepg_req_model req (.clk_in(CLOCK_IN), .req_out(RD_REQ_IN), .src_out(RD_SRC_IN),
        .addr_out(RD_ADDR_IN));
    task automatic chk(input logic [31:0] got, logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // Kind 0 program, 1 erase, 2 attribute
    task automatic op(input int k, logic [14:0] a, logic [31:0] dv);
        @(posedge CLOCK_IN);
        #1 {PROG_REQ_IN, ERASE_REQ_IN, ATTR_WE_IN, PROG_ADDR_IN, PROG_DATA_IN} = {3'h4 >> k, a, dv};
        @(posedge CLOCK_IN);
        #1 {PROG_REQ_IN, ERASE_REQ_IN, ATTR_WE_IN} = 3'h0;
        refd = OP_REFUSED_OUT;
    endtask
    task automatic rdchk(input logic [1:0] s, logic [14:0] a, logic [31:0] e, logic eb);
        req.rd(s, a);
        chk(RD_DATA_OUT, e);
        chk({RD_VALID_OUT, RD_BLOCKED_OUT}, {1'b1, eb});
    endtask
    task automatic t_open();
        op(1, 15'h2, 32'h0);
        chk(BUSY_OUT, 1'b1);
        repeat (256) @(posedge CLOCK_IN);
        #1 chk(BUSY_OUT, 1'b0);
        rdchk(2'h0, 15'h200, 32'hFFFFFFFF, 1'b0);
        rdchk(2'h1, 15'h2FF, 32'hFFFFFFFF, 1'b0);
        op(0, 15'h258, 32'h0F0F1234);
        rdchk(2'h2, 15'h258, 32'h0F0F1234, 1'b0);
        $display("open test done");
    endtask
    task automatic t_ro();
        op(2, 15'h1, 32'h1);
        op(0, 15'h2C0, 32'h0);
        chk({refd, VIOL_OUT}, 2'h3);
        rdchk(2'h1, 15'h2C0, 32'hFFFFFFFF, 1'b0);
        op(1, 15'h3, 32'h0);
        chk({refd, BUSY_OUT}, 2'h2);
        op(1, 15'h4, 32'h0);
        chk({refd, BUSY_OUT}, 2'h1);
        repeat (256) @(posedge CLOCK_IN);
        $display("read-only test done");
    endtask
    task automatic t_xo();
        op(2, 15'h1, 32'h2);
        rdchk(2'h1, 15'h258, 32'h0, 1'b1);
        rdchk(2'h2, 15'h258, 32'h0, 1'b1);
        rdchk(2'h0, 15'h258, 32'h0F0F1234, 1'b0);
        op(0, 15'h258, 32'h0);
        chk(refd, 1'b1);
        op(1, 15'h2, 32'h0);
        chk({refd, BUSY_OUT}, 2'h2);
        rdchk(2'h0, 15'h258, 32'h0F0F1234, 1'b0);
        $display("execute-only test done");
    endtask
    task automatic t_clear();
        @(posedge CLOCK_IN);
        #1 VIOL_CLR_IN = 1'b1;
        @(posedge CLOCK_IN);
        #1 VIOL_CLR_IN = 1'b0;
        chk(VIOL_OUT, 1'b0);
        @(posedge CLOCK_IN);
        #1 {PROG_REQ_IN, VIOL_CLR_IN, PROG_ADDR_IN} = {2'h3, 15'h258};
        @(posedge CLOCK_IN);
        #1 {PROG_REQ_IN, VIOL_CLR_IN} = 2'h0;
        chk({OP_REFUSED_OUT, VIOL_OUT}, 2'h3);
        $display("violation flag test done");
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    initial begin
        repeat (4) @(posedge CLOCK_IN);
        #1 SRST_IN = 1'b0;
        t_open();
        t_ro();
        t_xo();
        t_clear();
        report_and_stop();
    end
    // Whole run is near 554 cycles
    initial begin
        #100000 n_mismatch++;
        report_and_stop();
    end
endmodule // tb_top
